// *** cal_alarm_pkg.sv ***
package cal_alarm_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned BAUD_RATE = 2400;
  localparam int unsigned REPORT_SECONDS = 2;
  localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_RATE;
  localparam int unsigned REPORT_CYCLES = CLK_HZ * REPORT_SECONDS;
  localparam logic [31:0] CAL_TIME_RST = 32'h0000_4e20;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] CONC_OFS = 8'h00;
  localparam logic [7:0] RANGE_OFS = 8'h04;
  localparam logic [7:0] SPAN_OFS = 8'h08;
  localparam logic [7:0] SETPT1_OFS = 8'h0c;
  localparam logic [7:0] SETPT2_OFS = 8'h10;
  localparam logic [7:0] ALM_CFG_OFS = 8'h14;
  localparam logic [7:0] ALM_ACK_OFS = 8'h18;
  localparam logic [7:0] CAL_TIME_OFS = 8'h1c;
  localparam logic [7:0] STATUS_OFS = 8'h20;

  // reset values
  localparam logic [15:0] SPAN_RST = 16'h0064;
  localparam logic [15:0] SETPT_RST = 16'h03e8;
  localparam logic [1:0] RANGE_RST = 2'h0;

  // range encoding
  localparam logic [1:0] RNG_LOW = 2'h0;
  localparam logic [1:0] RNG_MED = 2'h1;
  localparam logic [1:0] RNG_HIGH = 2'h2;
  localparam logic [1:0] RNG_AIR = 2'h3;

  // 12-bit dac codes: quarter steps of full scale
  localparam logic [11:0] DAC_FULL = 12'hfff;
  localparam logic [11:0] DAC_Q1 = 12'h400;
  localparam logic [11:0] DAC_Q2 = 12'h800;
  localparam logic [11:0] DAC_Q3 = 12'hc00;

  // serial characters
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_A = 8'h61;
  localparam logic [7:0] CH_S = 8'h73;
  localparam logic [7:0] CH_Z = 8'h7a;
  localparam logic [7:0] CH_T = 8'h74;
  localparam logic [4:0] RPT_LAST = 5'h10;

  typedef enum logic [1:0] {CAL_IDLE, CAL_ZERO, CAL_SPAN} cal_state_t;

  // per-alarm attributes, reset: defeated, high acting
  typedef struct packed {
    logic defeat;
    logic latch;
    logic failsafe;
    logic high;
  } alm_cfg_t;
  localparam alm_cfg_t ALM_CFG_RST = 4'h9;

  // snapshot of one status line
  typedef struct packed {
    logic [15:0] conc;
    logic [1:0] range;
    logic [15:0] span;
    logic [1:0] disabled;
    logic [1:0] tripped;
  } rpt_t;

endpackage : cal_alarm_pkg

// *** remote_cal_alarm_status_ctrl.sv ***
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
// How it works
// - zero input starts zero calibration; still high at end repeats it
// - span input starts span calibration; still high at end repeats it
// - calibration contact closed during any calibration, open otherwise
// - remote inputs sampled only while analyzing (contact open)
// - requests during a running calibration are dropped, never queued
// - each threshold alarm is high acting or low acting
// - each threshold alarm has fail-safe, latching and defeat options
// - system alarm on supply fault or failed self test
// - system alarm always fail-safe, latching, never defeated
// - system alarm cleared by power key off, on, then non-system key
// - voltage range id output has one level per range
// - current range id output has one level per range
// - concentration outputs scale linearly to programmed full scale
// - exactly one range relay on; low, medium, high map to 1, 2, 3
// - fourth relay only for the air calibration range
// - status report sent every two seconds
// - report order: concentration, range, span, disabled, tripped
// - each status line ends in carriage return, line feed
// - span or zero command plus enter starts that calibration at once
// - pause command plus enter toggles periodic reporting
// - serial frame 2400 baud, 8 data bits, no parity, 1 stop
module remote_cal_alarm_status_ctrl
  import cal_alarm_pkg::*;
#(
  parameter int unsigned BIT_CNT = BIT_CYCLES,
  parameter int unsigned REPORT_CNT = REPORT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic zero_req,
  input wire logic span_req,
  input wire logic supply_fault,
  input wire logic selftest_fail,
  input wire logic power_key_on,
  input wire logic other_key,
  input wire logic rxd,
  output logic txd,
  output logic cal_busy_contact,
  output logic [1:0] alarm_relay,
  output logic sys_alarm_relay,
  output logic [3:0] range_relay,
  output logic [11:0] conc_volt_code,
  output logic [11:0] conc_cur_code,
  output logic [11:0] range_volt_code,
  output logic [11:0] range_cur_code
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [6:0] sync1_q, sync2_q;
  logic zero_s, span_s, fault_s, pkey_s, okey_s, rx_s;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 7'h50;
      sync2_q <= 7'h50;
    end else begin
      sync1_q <= {rxd, other_key, power_key_on, selftest_fail, supply_fault, span_req, zero_req};
      sync2_q <= sync1_q;
    end
  end
  // reset to each pin's idle level, so no false request or fault follows reset
  assign zero_s = sync2_q[0];
  assign span_s = sync2_q[1];
  assign fault_s = sync2_q[2] | sync2_q[3];
  assign pkey_s = sync2_q[4];
  assign okey_s = sync2_q[5];
  assign rx_s = sync2_q[6];

  // ---------------------------------------------------------------
  // registers and apb slave
  // ---------------------------------------------------------------
  logic [15:0] conc_q, span_q;
  logic [15:0] setpt_q [2];
  logic [1:0] range_q, ack_q, trip_q;
  alm_cfg_t cfg_q [2];
  logic [31:0] cal_time_q, rdata_d;
  cal_state_t cal_state_q, cal_state_d;
  logic sys_trip_q, report_run_q, map_d, wr_en;

  // reads answer one cycle after setup, zero wait states in access
  always_comb begin
    rdata_d = 32'h0;
    map_d = 1'b1;
    case (paddr)
      CONC_OFS: rdata_d = {16'h0, conc_q};
      RANGE_OFS: rdata_d = {30'h0, range_q};
      SPAN_OFS: rdata_d = {16'h0, span_q};
      SETPT1_OFS: rdata_d = {16'h0, setpt_q[0]};
      SETPT2_OFS: rdata_d = {16'h0, setpt_q[1]};
      ALM_CFG_OFS: rdata_d = {24'h0, cfg_q[1], cfg_q[0]};
      ALM_ACK_OFS: rdata_d = 32'h0;
      CAL_TIME_OFS: rdata_d = cal_time_q;
      STATUS_OFS: rdata_d = {26'h0, report_run_q, sys_trip_q, trip_q, cal_state_q};
      default: map_d = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~map_d;
      if (psel && !penable) begin
        prdata <= rdata_d;
      end
    end
  end
  assign wr_en = psel & penable & pready & pwrite & ~pslverr;

  // software-written configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conc_q <= 16'h0;
      range_q <= RANGE_RST;
      span_q <= SPAN_RST;
      setpt_q[0] <= SETPT_RST;
      setpt_q[1] <= SETPT_RST;
      cfg_q[0] <= ALM_CFG_RST;
      cfg_q[1] <= ALM_CFG_RST;
      cal_time_q <= CAL_TIME_RST;
      ack_q <= 2'h0;
    end else begin
      ack_q <= 2'h0;
      if (wr_en) begin
        case (paddr)
          CONC_OFS: conc_q <= pwdata[15:0];
          RANGE_OFS: range_q <= pwdata[1:0];
          SPAN_OFS: span_q <= pwdata[15:0];
          SETPT1_OFS: setpt_q[0] <= pwdata[15:0];
          SETPT2_OFS: setpt_q[1] <= pwdata[15:0];
          ALM_CFG_OFS: {cfg_q[1], cfg_q[0]} <= pwdata[7:0];
          ALM_ACK_OFS: ack_q <= pwdata[1:0];
          CAL_TIME_OFS: cal_time_q <= pwdata;
          default: ack_q <= 2'h0;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // remote calibration
  // ---------------------------------------------------------------
  logic [31:0] cal_cnt_q;
  logic cmd_zero_q, cmd_span_q, cmd_pause_q, cal_end;
  assign cal_end = (cal_cnt_q >= cal_time_q - 32'h1);

  // pins win over serial commands when both arrive together
  always_comb begin
    cal_state_d = cal_state_q;
    case (cal_state_q)
      CAL_IDLE: begin
        if (zero_s) begin
          cal_state_d = CAL_ZERO;
        end else if (span_s) begin
          cal_state_d = CAL_SPAN;
        end else if (cmd_zero_q) begin
          cal_state_d = CAL_ZERO;
        end else if (cmd_span_q) begin
          cal_state_d = CAL_SPAN;
        end
      end
      // requests seen here are dropped, nothing is remembered
      CAL_ZERO, CAL_SPAN: begin
        if (cal_end) begin
          cal_state_d = CAL_IDLE;
        end
      end
      default: cal_state_d = CAL_IDLE;
    endcase
  end

  // a held request retriggers from idle on the next cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_state_q <= CAL_IDLE;
      cal_busy_contact <= 1'b0;
      cal_cnt_q <= 32'h0;
    end else begin
      cal_state_q <= cal_state_d;
      cal_busy_contact <= (cal_state_d != CAL_IDLE);
      cal_cnt_q <= (cal_state_q == CAL_IDLE || cal_end) ? 32'h0 : cal_cnt_q + 32'h1;
    end
  end

  // ---------------------------------------------------------------
  // threshold alarms
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_alarm
    logic cond;
    assign cond = cfg_q[i].high ? (conc_q > setpt_q[i]) : (conc_q < setpt_q[i]);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        trip_q[i] <= 1'b0;
        alarm_relay[i] <= 1'b0;
      end else begin
        if (cfg_q[i].defeat) begin
          trip_q[i] <= 1'b0;
        end else if (cfg_q[i].latch) begin
          trip_q[i] <= cond | (trip_q[i] & ~ack_q[i]);
        end else begin
          trip_q[i] <= cond;
        end
        // fail-safe coil is energized while healthy
        alarm_relay[i] <= trip_q[i] ^ cfg_q[i].failsafe;
      end
    end
  end

  // ---------------------------------------------------------------
  // system alarm
  // ---------------------------------------------------------------
  logic pkey_prev_q, okey_prev_q, seen_off_q, armed_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_trip_q <= 1'b0;
      sys_alarm_relay <= 1'b0;
      pkey_prev_q <= 1'b1;
      okey_prev_q <= 1'b0;
      seen_off_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      pkey_prev_q <= pkey_s;
      okey_prev_q <= okey_s;
      if (!sys_trip_q) begin
        seen_off_q <= 1'b0;
        armed_q <= 1'b0;
      end else if (pkey_prev_q && !pkey_s) begin
        seen_off_q <= 1'b1;
        armed_q <= 1'b0;
      end else if (seen_off_q && !pkey_prev_q && pkey_s) begin
        armed_q <= 1'b1;
      end
      // a live fault wins over the clear sequence
      if (fault_s) begin
        sys_trip_q <= 1'b1;
      end else if (armed_q && okey_s && !okey_prev_q) begin
        sys_trip_q <= 1'b0;
      end
      sys_alarm_relay <= ~sys_trip_q;
    end
  end

  // ---------------------------------------------------------------
  // analog codes and range relays
  // ---------------------------------------------------------------
  logic [27:0] scaled;
  logic [11:0] conc_code;
  // widened first: a 16-bit product would wrap before the divide
  assign scaled = (span_q == 16'h0) ? 28'h0 : ({12'h0, conc_q} * {16'h0, DAC_FULL}) / {12'h0, span_q};
  assign conc_code = (conc_q >= span_q) ? DAC_FULL : scaled[11:0];

  // current dac maps code 0 to 4 mA and full code to 20 mA
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conc_volt_code <= 12'h0;
      conc_cur_code <= 12'h0;
      range_volt_code <= DAC_Q1;
      range_cur_code <= DAC_Q1;
      range_relay <= 4'h1;
    end else begin
      conc_volt_code <= conc_code;
      conc_cur_code <= conc_code;
      range_relay <= 4'(4'h1 << range_q);
      case (range_q)
        RNG_LOW: range_volt_code <= DAC_Q1;
        RNG_MED: range_volt_code <= DAC_Q2;
        RNG_HIGH: range_volt_code <= DAC_Q3;
        default: range_volt_code <= DAC_FULL;
      endcase
      case (range_q)
        RNG_LOW: range_cur_code <= DAC_Q1;
        RNG_MED: range_cur_code <= DAC_Q2;
        RNG_HIGH: range_cur_code <= DAC_Q3;
        default: range_cur_code <= DAC_FULL;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // serial receiver and command parser
  // ---------------------------------------------------------------
  logic rx_busy_q, rx_done_q;
  logic [15:0] rx_cnt_q;
  logic [3:0] rx_bit_q;
  logic [7:0] rx_sh_q, prev1_q, prev2_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_busy_q <= 1'b0;
      rx_done_q <= 1'b0;
      rx_cnt_q <= 16'h0;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 8'h0;
    end else begin
      rx_done_q <= 1'b0;
      if (!rx_busy_q) begin
        if (!rx_s) begin
          rx_busy_q <= 1'b1;
          rx_cnt_q <= 16'(BIT_CNT / 2);
          rx_bit_q <= 4'h0;
        end
      end else if (rx_cnt_q != 16'h0) begin
        rx_cnt_q <= rx_cnt_q - 16'h1;
      end else begin
        rx_cnt_q <= 16'(BIT_CNT - 1);
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q == 4'h0 && rx_s) begin
          rx_busy_q <= 1'b0; // glitch, not a start bit
        end else if (rx_bit_q == 4'h9) begin
          rx_busy_q <= 1'b0;
          rx_done_q <= rx_s;
        end else if (rx_bit_q != 4'h0) begin
          rx_sh_q <= {rx_s, rx_sh_q[7:1]};
        end
      end
    end
  end

  // two-letter commands are only honoured when enter follows at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev1_q <= 8'h0;
      prev2_q <= 8'h0;
      cmd_zero_q <= 1'b0;
      cmd_span_q <= 1'b0;
      cmd_pause_q <= 1'b0;
    end else begin
      cmd_zero_q <= 1'b0;
      cmd_span_q <= 1'b0;
      cmd_pause_q <= 1'b0;
      if (rx_done_q) begin
        if (rx_sh_q == CH_CR) begin
          cmd_span_q <= (prev2_q == CH_A) && (prev1_q == CH_S);
          cmd_zero_q <= (prev2_q == CH_A) && (prev1_q == CH_Z);
          cmd_pause_q <= (prev2_q == CH_S) && (prev1_q == CH_T);
          prev1_q <= 8'h0;
          prev2_q <= 8'h0;
        end else begin
          prev2_q <= prev1_q;
          prev1_q <= rx_sh_q;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // periodic status report
  // ---------------------------------------------------------------
  logic [31:0] rpt_cnt_q;
  logic rpt_tick, frame_q, tx_busy_q;
  logic [4:0] idx_q;
  logic [15:0] tx_cnt_q;
  logic [3:0] tx_bit_q;
  logic [9:0] tx_sh_q;
  rpt_t snap_q;

  function automatic logic [7:0] hex_ch(input logic [3:0] n);
    hex_ch = (n < 4'ha) ? 8'({4'h3, n}) : 8'(8'h37 + {4'h0, n});
  endfunction : hex_ch

  // fixed-width line; digits are hexadecimal to keep the encoder small
  function automatic logic [7:0] char_at(input rpt_t s, input logic [4:0] i);
    case (i)
      5'h00: char_at = hex_ch(s.conc[15:12]);
      5'h01: char_at = hex_ch(s.conc[11:8]);
      5'h02: char_at = hex_ch(s.conc[7:4]);
      5'h03: char_at = hex_ch(s.conc[3:0]);
      5'h05: char_at = hex_ch({2'h0, s.range});
      5'h07: char_at = hex_ch(s.span[15:12]);
      5'h08: char_at = hex_ch(s.span[11:8]);
      5'h09: char_at = hex_ch(s.span[7:4]);
      5'h0a: char_at = hex_ch(s.span[3:0]);
      5'h0c: char_at = hex_ch({2'h0, s.disabled});
      5'h0e: char_at = hex_ch({2'h0, s.tripped});
      5'h0f: char_at = CH_CR;
      5'h10: char_at = CH_LF;
      default: char_at = CH_SP;
    endcase
  endfunction : char_at

  assign rpt_tick = report_run_q && (rpt_cnt_q >= REPORT_CNT - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      report_run_q <= 1'b1;
      rpt_cnt_q <= 32'h0;
    end else begin
      if (cmd_pause_q) begin
        report_run_q <= ~report_run_q;
      end
      rpt_cnt_q <= (rpt_tick || !report_run_q) ? 32'h0 : rpt_cnt_q + 32'h1;
    end
  end

  // a late tick while a line is still going out is skipped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_q <= 1'b0;
      tx_busy_q <= 1'b0;
      idx_q <= 5'h0;
      tx_cnt_q <= 16'h0;
      tx_bit_q <= 4'h0;
      tx_sh_q <= 10'h3ff;
      snap_q <= '0;
      txd <= 1'b1;
    end else begin
      txd <= tx_busy_q ? tx_sh_q[0] : 1'b1;
      if (!frame_q) begin
        if (rpt_tick) begin
          frame_q <= 1'b1;
          tx_busy_q <= 1'b0;
          idx_q <= 5'h0;
          snap_q <= '{conc_q, range_q, span_q, {cfg_q[1].defeat, cfg_q[0].defeat}, trip_q};
        end
      end else if (!tx_busy_q) begin
        tx_busy_q <= 1'b1;
        tx_sh_q <= {1'b1, char_at(snap_q, idx_q), 1'b0};
        tx_cnt_q <= 16'(BIT_CNT - 1);
        tx_bit_q <= 4'h0;
      end else if (tx_cnt_q != 16'h0) begin
        tx_cnt_q <= tx_cnt_q - 16'h1;
      end else if (tx_bit_q == 4'h9) begin
        tx_busy_q <= 1'b0;
        idx_q <= idx_q + 5'h1;
        frame_q <= (idx_q != RPT_LAST);
      end else begin
        tx_cnt_q <= 16'(BIT_CNT - 1);
        tx_bit_q <= tx_bit_q + 4'h1;
        tx_sh_q <= {1'b1, tx_sh_q[9:1]};
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence seq_cal_done;
    (cal_state_q != CAL_IDLE) && cal_end ##1 (cal_state_q == CAL_IDLE);
  endsequence
  sequence seq_quiet;
    !zero_s && !span_s && !cmd_zero_q && !cmd_span_q;
  endsequence

  AST_ZERO_START: assert property ((cal_state_q == CAL_IDLE) && zero_s |=> (cal_state_q == CAL_ZERO))
    else $error("zero request did not start zero calibration");
  AST_SPAN_START: assert property ((cal_state_q == CAL_IDLE) && !zero_s && span_s |=> (cal_state_q == CAL_SPAN))
    else $error("span request did not start span calibration");
  AST_CONTACT: assert property (cal_busy_contact == (cal_state_q != CAL_IDLE))
    else $error("calibration contact disagrees with calibration state");
  AST_NO_QUEUE: assert property (seq_cal_done ##0 seq_quiet |=> (cal_state_q == CAL_IDLE) [*2])
    else $error("calibration started without a fresh request");
  AST_REPEAT: assert property (seq_cal_done ##0 zero_s |=> (cal_state_q == CAL_ZERO) ##1 cal_busy_contact)
    else $error("held zero request did not repeat calibration");
  AST_HIGH_TRIP: assert property (!cfg_q[0].defeat && cfg_q[0].high && (conc_q > setpt_q[0]) |=> trip_q[0])
    else $error("high acting alarm missed its threshold");
  AST_DEFEAT: assert property (cfg_q[1].defeat |=> !trip_q[1])
    else $error("defeated alarm tripped");
  AST_LATCH: assert property (trip_q[0] && cfg_q[0].latch && !cfg_q[0].defeat && !ack_q[0] && $stable(cfg_q[0])
    |=> trip_q[0])
    else $error("latched alarm dropped without acknowledge");
  AST_SYS_FAULT: assert property (fault_s |=> sys_trip_q ##1 !sys_alarm_relay)
    else $error("system alarm did not actuate on fault");
  AST_RANGE_RELAY: assert property ($onehot(range_relay) and ((range_q != RNG_AIR) |-> ##1 !range_relay[3]))
    else $error("range relays not exactly one");
  AST_PAUSE: assert property (cmd_pause_q |=> (report_run_q != $past(report_run_q)))
    else $error("pause command did not toggle reporting");
  AST_LINE_END: assert property (frame_q && !tx_busy_q && (idx_q == RPT_LAST) |=> (tx_sh_q[8:1] == CH_LF))
    else $error("status line does not end in line feed");

endmodule : remote_cal_alarm_status_ctrl

// *** host_ctrl_model.sv ***
`timescale 1ns/1ps
// ---------------------------------
// process controller and terminal
// ---------------------------------
module host_ctrl_model #(
  parameter int BIT_CNT = 16
) (
  input wire logic pclk,
  input wire logic cal_busy_contact,
  output logic zero_req,
  output logic span_req,
  output logic rxd
);
  // idle: no request, line high
  initial begin
    zero_req = 1'b0;
    span_req = 1'b0;
    rxd = 1'b1;
  end
  // request while open, drop once closed; hold keeps it past the end
  task automatic cal_req(input logic span, input logic hold, output logic ok);
    int n;
    ok = 1'b0;
    for (n = 0; n < 3000 && cal_busy_contact; n++) @(negedge pclk);
    @(posedge pclk);
    zero_req <= !span;
    span_req <= span;
    for (n = 0; n < 8 && !ok; n++) @(negedge pclk) ok = cal_busy_contact;
    if (hold) begin
      for (n = 0; n < 40 && cal_busy_contact; n++) @(negedge pclk);
      for (n = 0; n < 4 && !cal_busy_contact; n++) @(negedge pclk);
      ok = ok & cal_busy_contact;
    end
    @(posedge pclk);
    zero_req <= 1'b0;
    span_req <= 1'b0;
  endtask : cal_req
  // lsb first, stop bit leaves the line high
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    @(posedge pclk);
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (BIT_CNT) @(posedge pclk);
    end
  endtask : send_byte
endmodule : host_ctrl_model

// *** remote_cal_alarm_status_ctrl_tb.sv ***
`timescale 1ns/1ps
module remote_cal_alarm_status_ctrl_tb
  import cal_alarm_pkg::*;
();
  localparam int BITS = 16;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, ok;
  logic supply_fault, selftest_fail, power_key_on, other_key, zero_req, span_req, rxd, txd;
  logic cal_busy_contact, sys_alarm_relay;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] alarm_relay;
  logic [3:0] range_relay;
  logic [11:0] conc_volt_code, conc_cur_code, range_volt_code, range_cur_code;
  logic [7:0] line [17];
  logic [11:0] rc [4];
  logic [24:0] at [6];
  int mismatches, checks_done, n;

  remote_cal_alarm_status_ctrl #(.BIT_CNT(BITS), .REPORT_CNT(2000)) remote_cal_alarm_status_ctrl_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .zero_req, .span_req, .supply_fault, .selftest_fail, .power_key_on, .other_key, .rxd, .txd,
    .cal_busy_contact, .alarm_relay, .sys_alarm_relay, .range_relay, .conc_volt_code, .conc_cur_code,
    .range_volt_code, .range_cur_code);
  host_ctrl_model #(.BIT_CNT(BITS)) host_ctrl_model_inst (
    .pclk, .cal_busy_contact, .zero_req, .span_req, .rxd);

  // ---------------------------------
  // clock, tasks
  // ---------------------------------
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    if (k == 16) chk(32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wt(input int c);
    repeat (c) @(negedge pclk);
  endtask : wt
  // fault, self test, power key, other key
  task automatic key(input logic [3:0] v);
    @(posedge pclk) {supply_fault, selftest_fail, power_key_on, other_key} <= v;
    wt(5);
  endtask : key
  task automatic cmd(input logic [7:0] c1, input logic [7:0] c2);
    host_ctrl_model_inst.send_byte(c1);
    host_ctrl_model_inst.send_byte(c2);
    host_ctrl_model_inst.send_byte(CH_CR);
  endtask : cmd
  // sample each bit mid-cell, return at stop-bit middle
  task automatic rx_byte(output logic [7:0] b);
    for (n = 0; n < 3000 && txd !== 1'b0; n++) @(negedge pclk);
    wt(BITS / 2);
    for (int i = 0; i < 8; i++) begin
      wt(BITS);
      b[i] = txd;
    end
    wt(BITS);
  endtask : rx_byte
  task automatic finish_test;
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  // hang guard, well beyond the expected run
  initial begin
    repeat (60000) @(posedge pclk);
    mismatches++;
    finish_test();
  end

  // ---------------------------------
  // scenarios
  // ---------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, supply_fault, selftest_fail, other_key} = '0;
    power_key_on = 1'b1;
    presetn = 1'b0;
    rc = '{DAC_Q1, DAC_Q2, DAC_Q3, DAC_FULL};
    at = '{{8'h90, 16'h5, 1'b1}, {8'h90, 16'h32, 1'b0}, {8'h92, 16'h32, 1'b1},
           {8'h98, 16'h5, 1'b0}, {8'h95, 16'h32, 1'b1}, {8'h95, 16'h5, 1'b1}};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, SPAN_OFS, 32'h0);
    chk(rd, {16'h0, SPAN_RST});
    apb(1'b0, ALM_CFG_OFS, 32'h0);
    chk(rd, 32'h99);
    apb(1'b0, 8'h40, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    // first line after reset: conc 0000, range 0
    for (int i = 0; i < 17; i++) rx_byte(line[i]);
    chk({line[0], line[4], line[5]}, {8'h30, CH_SP, 8'h30});
    chk({line[15], line[16]}, {CH_CR, CH_LF});
    cmd(CH_S, CH_T);
    for (n = 0; n < 2500 && txd === 1'b1; n++) @(negedge pclk);
    chk(n, 2500);
    cmd(CH_S, CH_T);
    for (n = 0; n < 3000 && txd !== 1'b0; n++) @(negedge pclk);
    chk(n >= 1900 && n <= 2100, 32'h1);
    for (int i = 1; i < 3; i++) begin
      apb(1'b1, CONC_OFS, 32'h32 * i);
      wt(3);
      chk({conc_volt_code, conc_cur_code}, (i == 1) ? 24'h7ff7ff : 24'hffffff);
    end
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, RANGE_OFS, 32'(r));
      wt(3);
      chk(range_relay, 4'h1 << r);
      chk({range_volt_code, range_cur_code}, {rc[r], rc[r]});
    end
    apb(1'b1, SETPT1_OFS, 32'h10);
    foreach (at[i]) begin
      apb(1'b1, ALM_CFG_OFS, {24'h0, at[i][24:17]});
      apb(1'b1, CONC_OFS, {16'h0, at[i][16:1]});
      wt(4);
      chk(alarm_relay[0], at[i][0]);
    end
    apb(1'b1, ALM_ACK_OFS, 32'h1);
    wt(4);
    chk(alarm_relay[0], 1'b0);
    apb(1'b1, CAL_TIME_OFS, 32'ha);
    for (int s = 0; s < 2; s++) begin
      host_ctrl_model_inst.cal_req(s[0], 1'b0, ok);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk({ok, rd[1:0]}, {1'b1, s[0] ? CAL_SPAN : CAL_ZERO});
    end
    host_ctrl_model_inst.cal_req(1'b0, 1'b1, ok);
    wt(40);
    chk({ok, cal_busy_contact}, 2'b10);
    chk(sys_alarm_relay, 1'b1);
    key(4'b1010);
    key(4'b0010);
    key(4'b0011);
    chk(sys_alarm_relay, 1'b0);
    key(4'b0000);
    key(4'b0010);
    key(4'b0011);
    chk(sys_alarm_relay, 1'b1);
    key(4'b0110);
    key(4'b0010);
    chk(sys_alarm_relay, 1'b0);
    apb(1'b1, CAL_TIME_OFS, 32'h7d0);
    cmd(CH_A, CH_Z);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk({cal_busy_contact, rd[1:0]}, {1'b1, CAL_ZERO});
    cmd(CH_A, CH_S);
    for (n = 0; n < 3000 && cal_busy_contact; n++) @(negedge pclk);
    wt(20);
    chk(cal_busy_contact, 1'b0);
    cmd(CH_A, CH_S);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk({cal_busy_contact, rd[1:0]}, {1'b1, CAL_SPAN});
    finish_test();
  end
endmodule : remote_cal_alarm_status_ctrl_tb
